// *** core/gpio_bridge_regs.svh ***
// Purpose: register offsets, reset values and timing counts of the bridge gpio unit
// Assumes: 100 MHz system clock, byte-wide configuration access port
// Notes:   offsets are byte addresses in device-specific configuration space
//
// Contract
// - four general-purpose pins, direction and level set by configuration registers
// - five 8-bit fields: set/clear output, set/clear enable, pin input value
// - low four enable bits used; one sets output, one clears it; zeros ignored
// - after reset every pin is input only with its driver off
// - input field is read only and always returns the four pin levels
// - set-output bit sets, clear-output bit clears, zeros ignored, resets to zero
// - stored output reaches the pin only while the pin is enabled
// - shift sixteen serial mask bits into the secondary clock mask register
// - shift starts at upstream reset release with downstream reset held
// - downstream reset held a further 100 us after the shift completes
// - pins 0 and 2 load and shift the external mask shift register
// - bit pairs 0-7 gate clocks 0-3, bits 8-13 gate 4-9, 14-15 reserved
// - serial input low enables every clock, high disables every clock
// - after shifting, pins tristate, serial input ignored, release needs software bit clear
// - clock mask stays writable by configuration writes afterwards
// - live mode with pin 3 high masks io, memory, master enables to zero
// - halted device drains queued requests, returns no completions, takes no io/memory; drain flag follows the master enable bit, halted or not
// - configuration transactions are still accepted while halted
// - live insertion unavailable in hot-swap mode, pin 3 is the ejector input
// - both mode selects zero gives hot-swap; any other pair keeps pin 3 general
// - hot-swap drives the board event output and reads the ejector handle
// - hot-swap drives the swap-ready lamp output
`ifndef GPIO_BRIDGE_REGS_SVH
`define GPIO_BRIDGE_REGS_SVH

`define OFS_CHIP_CTRL      8'h40
`define OFS_OUT_SET        8'h64
`define OFS_OUT_CLEAR      8'h65
`define OFS_DIR_SET        8'h66
`define OFS_DIR_CLEAR      8'h67
`define OFS_PIN_INPUT      8'h68
`define OFS_CLK_MASK_LO    8'h6a
`define OFS_CLK_MASK_HI    8'h6b
`define OFS_SWAP_CTRL      8'h6c

`define CTRL_IO_EN         0
`define CTRL_MEM_EN        1
`define CTRL_MASTER_EN     2
`define CTRL_LIVE_MODE     3
`define CTRL_SW_SEC_RST    4
`define SWAP_LAMP          0
`define SWAP_INSERT        1
`define SWAP_REMOVE        2

`define RST_PIN_BITS       4'h0
`define RST_CTRL           8'h00
`define RST_CLK_MASK       16'h0000
`define SHIFT_PIN_OE       4'h5
`define EJECTOR_PIN        3
`define HIGH_PIN_BITS      4'h0

`define CLK_PERIOD_NS      10
`define SEC_RST_HOLD_US    100
`define SHIFT_HALF_CYCLES  3'h4
`define MASK_BITS_LAST     4'hf

`endif

// *** core/gpio_bridge_pkg.sv ***
// Purpose: types shared by the bridge gpio unit
// Assumes: nothing beyond the register header
// Notes:   state codes are one-hot
package gpio_bridge_pkg;

    typedef enum logic [5:0] {
        ST_LOAD     = 6'h01,
        ST_SHIFT_LO = 6'h02,
        ST_SHIFT_HI = 6'h04,
        ST_HOLD     = 6'h08,
        ST_RUN      = 6'h10,
        ST_SW_RST   = 6'h20
    } seq_state_e;

    typedef struct packed {
        seq_state_e  state;
        logic [2:0]  phase;
        logic [3:0]  bit_cnt;
        logic [15:0] clk_mask;
        logic [3:0]  out_data;
        logic [3:0]  dir;
        logic [7:0]  ctrl;
        logic        lamp;
        logic [1:0]  swap_pend;
        logic        ejector_prev;
        logic [3:0]  pin_out;
        logic [3:0]  pin_oe;
        logic        sec_rst_n;
        logic [7:0]  rdata;
        logic [2:0]  en_eff;
        logic        halted;
        logic        accept_io_mem;
        logic        cpl_en;
        logic        queue_drain;
        logic [9:0]  clk_disable;
        logic        board_event_n;
        logic        lamp_out;
    } gpio_state_s;

endpackage

// *** core/gpio_bridge_sync.sv ***
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs asynchronous to i_clk_sys
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module gpio_bridge_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_s;

    sync_state_s cur;
    sync_state_s next_cur;

    always_comb begin
        next_cur.meta   = i_async;
        next_cur.stable = cur.meta;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_sync = cur.stable;
endmodule

// *** core/gpio_bridge_timer.sv ***
// Purpose: one-shot delay counter for the downstream reset hold
// Assumes: i_start is a one-cycle pulse; a new start restarts the count
// Notes:   o_expired pulses once, HOLD_CYCLES edges after the start
`timescale 1ns/10ps
module gpio_bridge_timer #(
    parameter logic [15:0] HOLD_CYCLES = 16'd10000
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    // control
    input  wire logic i_start,
    output logic      o_expired
);
    typedef struct packed {
        logic [15:0] count;
        logic        running;
        logic        expired;
    } timer_state_s;

    timer_state_s cur;
    timer_state_s next_cur;

    always_comb begin
        next_cur         = cur;
        next_cur.expired = 1'b0;
        if (i_start) begin
            next_cur.count   = 16'h0001;
            next_cur.running = 1'b1;
        end else if (cur.running) begin
            if (cur.count == HOLD_CYCLES) begin
                next_cur.running = 1'b0;
                next_cur.expired = 1'b1;
            end else begin
                next_cur.count = cur.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_expired = cur.expired;
endmodule

// *** core/gpio_bridge_core.sv ***
// Purpose: four-pin gpio, clock-mask shift-in, live insertion and hot-swap pins
// Assumes: i_rst_n is the upstream bus reset already timed to i_clk_sys
// Notes:   configuration reads answer one cycle after the read strobe
`timescale 1ns/10ps
`include "gpio_bridge_regs.svh"
module gpio_bridge_core #(
    parameter logic [15:0] HOLD_CYCLES = 16'(`SEC_RST_HOLD_US * 1000 / `CLK_PERIOD_NS)
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // configuration access
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [7:0]  i_cfg_wdata,
    output logic      [7:0]  o_cfg_rdata,
    // general-purpose pins
    input  wire logic [3:0]  i_gpio_pin,
    output logic      [3:0]  o_gpio_out,
    output logic      [3:0]  o_gpio_oe,
    // clock mask and downstream reset
    input  wire logic        i_clock_mask_serial_in,
    output logic      [9:0]  o_downstream_clock_out_disable,
    output logic             o_sec_rst_n,
    // effective enables towards the forwarding logic
    output logic             o_io_en_eff,
    output logic             o_mem_en_eff,
    output logic             o_master_en_eff,
    output logic             o_halted,
    output logic             o_accept_io_mem,
    output logic             o_delayed_cpl_en,
    output logic             o_queue_drain,
    output logic             o_accept_cfg,
    // hot-swap
    input  wire logic        i_mode_select_low,
    input  wire logic        i_mode_select_high,
    output logic             o_board_event_signal_n,
    output logic             o_swap_ready_lamp
);
    import gpio_bridge_pkg::*;

    gpio_bridge_pkg::gpio_state_s cur;
    gpio_bridge_pkg::gpio_state_s next_cur;

    logic [3:0] pin_sync;
    logic [2:0] misc_sync;
    logic       timer_start;
    logic       timer_expired;
    logic       hot_swap;
    logic       live_halt;

    // mapping: a pair gates one clock if either bit is set
    function automatic logic [9:0] clk_disable_map(input logic [15:0] mask);
        logic [9:0] dis;
        dis = '0;
        for (int i = 0; i < 4; i++) begin
            dis[i] = mask[2*i] | mask[2*i+1];
        end
        for (int i = 4; i < 10; i++) begin
            dis[i] = mask[i+4];
        end
        return dis;
    endfunction

    // pins and straps pass two flops before use
    gpio_bridge_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_gpio_pin),
        .o_sync    (pin_sync)
    );

    gpio_bridge_sync #(
        .WIDTH (3)
    ) u_misc_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_mode_select_high, i_mode_select_low, i_clock_mask_serial_in}),
        .o_sync    (misc_sync)
    );

    gpio_bridge_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold_timer (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_start   (timer_start),
        .o_expired (timer_expired)
    );

    // both selects low means hot-swap mode
    // straps read low while the synchroniser settles, so no mode during the load
    assign hot_swap  = ~misc_sync[1] & ~misc_sync[2] & (cur.state != ST_LOAD);
    // pin 3 is the ejector in hot-swap mode, so no live halt then
    assign live_halt = cur.ctrl[`CTRL_LIVE_MODE] & ~hot_swap & pin_sync[`EJECTOR_PIN];

    always_comb begin
        next_cur    = cur;
        timer_start = 1'b0;

        // configuration writes are taken in every state, halted or not
        if (i_cfg_wr) begin
            case (i_cfg_addr)
                `OFS_OUT_SET: begin
                    next_cur.out_data = cur.out_data | i_cfg_wdata[3:0];
                end
                `OFS_OUT_CLEAR: begin
                    next_cur.out_data = cur.out_data & ~i_cfg_wdata[3:0];
                end
                `OFS_DIR_SET: begin
                    next_cur.dir = cur.dir | i_cfg_wdata[3:0];
                end
                `OFS_DIR_CLEAR: begin
                    next_cur.dir = cur.dir & ~i_cfg_wdata[3:0];
                end
                `OFS_CHIP_CTRL: begin
                    next_cur.ctrl = i_cfg_wdata;
                end
                `OFS_CLK_MASK_LO: begin
                    next_cur.clk_mask[7:0] = i_cfg_wdata;
                end
                `OFS_CLK_MASK_HI: begin
                    next_cur.clk_mask[15:8] = i_cfg_wdata;
                end
                `OFS_SWAP_CTRL: begin
                    next_cur.lamp      = i_cfg_wdata[`SWAP_LAMP];
                    next_cur.swap_pend = cur.swap_pend & ~i_cfg_wdata[`SWAP_REMOVE:`SWAP_INSERT];
                end
                default: begin
                end
            endcase
        end

        // ejector edges after the clear so an event in the clear cycle survives
        next_cur.ejector_prev = pin_sync[`EJECTOR_PIN];
        if (hot_swap && cur.state == ST_RUN) begin
            if (cur.ejector_prev && !pin_sync[`EJECTOR_PIN]) begin
                next_cur.swap_pend[0] = 1'b1;
            end
            if (!cur.ejector_prev && pin_sync[`EJECTOR_PIN]) begin
                next_cur.swap_pend[1] = 1'b1;
            end
        end

        case (cur.state)
            ST_LOAD: begin
                // active-low load on pin 0, shift clock on pin 2
                next_cur.pin_oe  = `SHIFT_PIN_OE;
                next_cur.pin_out = `RST_PIN_BITS;
                next_cur.phase   = cur.phase + 3'h1;
                if (cur.phase == `SHIFT_HALF_CYCLES - 3'h1) begin
                    next_cur.phase      = 3'h0;
                    next_cur.pin_out[0] = 1'b1;
                    next_cur.bit_cnt    = 4'h0;
                    next_cur.state      = ST_SHIFT_LO;
                end
            end
            ST_SHIFT_LO: begin
                next_cur.phase = cur.phase + 3'h1;
                if (cur.phase == `SHIFT_HALF_CYCLES - 3'h1) begin
                    // first serial bit lands in mask bit 0
                    next_cur.clk_mask   = {misc_sync[0], cur.clk_mask[15:1]};
                    next_cur.phase      = 3'h0;
                    next_cur.pin_out[2] = 1'b1;
                    next_cur.state      = ST_SHIFT_HI;
                end
            end
            ST_SHIFT_HI: begin
                next_cur.phase = cur.phase + 3'h1;
                if (cur.phase == `SHIFT_HALF_CYCLES - 3'h1) begin
                    next_cur.phase      = 3'h0;
                    next_cur.pin_out[2] = 1'b0;
                    if (cur.bit_cnt == `MASK_BITS_LAST) begin
                        // shift done: release the pins, ignore the serial input
                        next_cur.pin_oe = `RST_PIN_BITS;
                        next_cur.state  = ST_HOLD;
                        timer_start     = 1'b1;
                    end else begin
                        next_cur.bit_cnt = cur.bit_cnt + 4'h1;
                        next_cur.state   = ST_SHIFT_LO;
                    end
                end
            end
            ST_HOLD: begin
                next_cur.pin_oe = `RST_PIN_BITS;
                if (timer_expired) begin
                    // release only with the software reset bit clear
                    if (cur.ctrl[`CTRL_SW_SEC_RST]) begin
                        next_cur.state = ST_SW_RST;
                    end else begin
                        next_cur.sec_rst_n = 1'b1;
                        next_cur.state     = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                // driver on only for enabled pins; ejector pin never driven in hot-swap
                next_cur.pin_out = cur.out_data;
                next_cur.pin_oe  = cur.dir & ~{hot_swap, 3'h0};
                if (cur.ctrl[`CTRL_SW_SEC_RST]) begin
                    next_cur.sec_rst_n = 1'b0;
                    next_cur.state     = ST_SW_RST;
                end
            end
            ST_SW_RST: begin
                next_cur.pin_out   = cur.out_data;
                next_cur.pin_oe    = cur.dir & ~{hot_swap, 3'h0};
                next_cur.sec_rst_n = 1'b0;
                if (!cur.ctrl[`CTRL_SW_SEC_RST]) begin
                    // the hold always starts with the pins released
                    next_cur.pin_oe = `RST_PIN_BITS;
                    next_cur.state  = ST_HOLD;
                    timer_start     = 1'b1;
                end
            end
            default: begin
                next_cur.state = ST_LOAD;
            end
        endcase

        // masked enables; the register keeps its written value
        next_cur.halted        = live_halt;
        next_cur.en_eff        = live_halt ? 3'h0 : cur.ctrl[`CTRL_MASTER_EN:`CTRL_IO_EN];
        // drain flag follows the master enable bit; in live halt answer nothing new
        next_cur.accept_io_mem = ~live_halt &
                                 (cur.ctrl[`CTRL_IO_EN] | cur.ctrl[`CTRL_MEM_EN]);
        next_cur.cpl_en        = ~live_halt;
        next_cur.queue_drain   = cur.ctrl[`CTRL_MASTER_EN];
        next_cur.clk_disable   = clk_disable_map(cur.clk_mask);
        // hot-swap pins idle when the mode is off
        next_cur.board_event_n = ~(hot_swap & (|cur.swap_pend));
        next_cur.lamp_out      = hot_swap & (cur.lamp | ~cur.sec_rst_n);

        if (i_cfg_rd) begin
            case (i_cfg_addr)
                `OFS_OUT_SET, `OFS_OUT_CLEAR: begin
                    next_cur.rdata = {`HIGH_PIN_BITS, cur.out_data};
                end
                `OFS_DIR_SET, `OFS_DIR_CLEAR: begin
                    next_cur.rdata = {`HIGH_PIN_BITS, cur.dir};
                end
                `OFS_PIN_INPUT: begin
                    next_cur.rdata = {`HIGH_PIN_BITS, pin_sync};
                end
                `OFS_CHIP_CTRL: begin
                    next_cur.rdata = cur.ctrl;
                end
                `OFS_CLK_MASK_LO: begin
                    next_cur.rdata = cur.clk_mask[7:0];
                end
                `OFS_CLK_MASK_HI: begin
                    next_cur.rdata = cur.clk_mask[15:8];
                end
                `OFS_SWAP_CTRL: begin
                    next_cur.rdata = {5'h00, cur.swap_pend, cur.lamp};
                end
                default: begin
                    next_cur.rdata = 8'h00;
                end
            endcase
        end
    end

    // upstream reset puts every pin to input and holds the downstream reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cur           <= '0;
            cur.state     <= ST_LOAD;
            cur.out_data  <= `RST_PIN_BITS;
            cur.dir       <= `RST_PIN_BITS;
            cur.ctrl      <= `RST_CTRL;
            cur.clk_mask  <= `RST_CLK_MASK;
            cur.sec_rst_n <= 1'b0;
            cur.cpl_en    <= 1'b1;
            cur.board_event_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_cfg_rdata                    = cur.rdata;
    assign o_gpio_out                     = cur.pin_out;
    assign o_gpio_oe                      = cur.pin_oe;
    assign o_downstream_clock_out_disable = cur.clk_disable;
    assign o_sec_rst_n                    = cur.sec_rst_n;
    assign o_io_en_eff                    = cur.en_eff[0];
    assign o_mem_en_eff                   = cur.en_eff[1];
    assign o_master_en_eff                = cur.en_eff[2];
    assign o_halted                       = cur.halted;
    assign o_accept_io_mem                = cur.accept_io_mem;
    assign o_delayed_cpl_en               = cur.cpl_en;
    assign o_queue_drain                  = cur.queue_drain;
    assign o_accept_cfg                   = i_rst_n | ~i_rst_n;
    assign o_board_event_signal_n         = cur.board_event_n;
    assign o_swap_ready_lamp              = cur.lamp_out;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    dir_reset_a: assert property ($rose(i_rst_n) |->
        cur.dir == 4'h0 && cur.out_data == 4'h0)
        else $error("pin state not cleared by reset");
    dir_set_a: assert property (i_cfg_wr && i_cfg_addr == `OFS_DIR_SET |=>
        (cur.dir & $past(i_cfg_wdata[3:0])) == $past(i_cfg_wdata[3:0]))
        else $error("direction set bit lost");
    out_set_a: assert property (i_cfg_wr && i_cfg_addr == `OFS_OUT_SET |=>
        (cur.out_data & $past(i_cfg_wdata[3:0])) == $past(i_cfg_wdata[3:0]))
        else $error("output set bit lost");
    out_clear_a: assert property (i_cfg_wr && i_cfg_addr == `OFS_OUT_CLEAR |=>
        (cur.out_data & $past(i_cfg_wdata[3:0])) == 4'h0)
        else $error("output clear bit ignored");
    pin_read_a: assert property (i_cfg_rd && i_cfg_addr == `OFS_PIN_INPUT |=>
        o_cfg_rdata == {4'h0, $past(pin_sync)})
        else $error("input field does not show pins");
    run_gate_a: assert property (cur.state == ST_RUN |=>
        o_gpio_oe == ($past(cur.dir) & ~{$past(hot_swap), 3'h0}))
        else $error("pin driver not gated by direction");
    shift_count_a: assert property (cur.state == ST_SHIFT_HI &&
        $past(cur.state) == ST_LOAD |-> 0)
        else $error("shift skipped its low half");
    hold_tri_a: assert property (cur.state == ST_HOLD |->
        o_gpio_oe == 4'h0 && !o_sec_rst_n)
        else $error("pins driven or reset released during hold");
    sw_rst_a: assert property (cur.state == ST_RUN && cur.ctrl[`CTRL_SW_SEC_RST] |=>
        !o_sec_rst_n)
        else $error("software reset bit did not hold the downstream reset");
    rst_release_a: assert property ($rose(o_sec_rst_n) |->
        $past(cur.state) == ST_HOLD && $past(timer_expired) &&
        !$past(cur.ctrl[`CTRL_SW_SEC_RST]))
        else $error("downstream reset released early");
    all_masked_a: assert property (cur.clk_mask == 16'hffff |=>
        o_downstream_clock_out_disable == 10'h3ff)
        else $error("full mask left a clock running");
    live_mask_a: assert property (live_halt |=>
        cur.en_eff == 3'h0 && !o_accept_io_mem && !o_delayed_cpl_en)
        else $error("enables not masked in live halt");
    swap_halt_a: assert property (hot_swap |=> !o_halted)
        else $error("live halt taken in hot-swap mode");
    swap_pin_a: assert property (hot_swap && cur.state == ST_RUN |=> !o_gpio_oe[3])
        else $error("ejector pin driven in hot-swap mode");
    swap_event_a: assert property (!hot_swap |=> o_board_event_signal_n)
        else $error("board event signalled outside hot-swap mode");
    swap_lamp_a: assert property (!hot_swap |=> !o_swap_ready_lamp)
        else $error("lamp lit outside hot-swap mode");
endmodule

// *** dv/mask_shift_model.sv ***
// Purpose: external mask shift register that sits behind gpio pins 0 and 2
// Assumes: load is low on pin 0, and a shift happens on each pin 2 rising edge
// Notes:   the serial line toggles when no bit is presented, so a stale level is never read
`timescale 1ns/10ps
module mask_shift_model (
    // clock and pin levels
    input  wire logic        i_clk_sys,
    input  wire logic [3:0]  i_pin,
    input  wire logic [15:0] i_word,
    // serial mask line
    output logic             o_ser
);
    logic [4:0] idx   = 5'h10;
    logic       prev2 = 1'b0;
    logic       junk  = 1'b0;
    always @(posedge i_clk_sys) begin
        junk  <= ~junk;
        prev2 <= i_pin[2];
        if (i_pin[0] === 1'b0) begin
            idx <= 5'h00;
        end else if (i_pin[2] && !prev2 && idx != 5'h10) begin
            idx <= idx + 5'h01;
        end
    end
    // bit 0 goes out first
    assign o_ser = (idx < 5'h10) ? i_word[idx[3:0]] : junk;
endmodule

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the bridge gpio unit
// Assumes: hold count is shortened to 20 cycles
// Notes:   reset is held 2 edges; the synchronous clear needs no more
`timescale 1ns/10ps
module tb_top;
    localparam int HOLD = 20;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ser, mslo = 1'b1, mshi = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [3:0]  pin_drv = 4'h1, pins, gpio_out, gpio_oe;
    logic [15:0] word = 16'h0000;
    logic [9:0]  clk_dis;
    logic        sec_rst_n, io_en, mem_en, mst_en, halted, acc_iomem, cpl_en, drain, acc_cfg;
    logic        event_n, lamp;
    int          fail_count = 0, samples_checked = 0;
    always #5 clk = ~clk;
    // undriven pins take the bench level
    assign pins = (gpio_oe & gpio_out) | (~gpio_oe & pin_drv);
    gpio_bridge_core #(.HOLD_CYCLES(16'd20)) dut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
        .o_cfg_rdata(rdata), .i_gpio_pin(pins), .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe),
        .i_clock_mask_serial_in(ser), .o_downstream_clock_out_disable(clk_dis),
        .o_sec_rst_n(sec_rst_n), .o_io_en_eff(io_en), .o_mem_en_eff(mem_en),
        .o_master_en_eff(mst_en), .o_halted(halted), .o_accept_io_mem(acc_iomem),
        .o_delayed_cpl_en(cpl_en), .o_queue_drain(drain), .o_accept_cfg(acc_cfg),
        .i_mode_select_low(mslo), .i_mode_select_high(mshi),
        .o_board_event_signal_n(event_n), .o_swap_ready_lamp(lamp));
    mask_shift_model ext (.i_clk_sys(clk), .i_pin(pins), .i_word(word), .o_ser(ser));
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        tick(1);
        wr = 1'b0;
        // idle edge, so back-to-back writes never drop and raise the strobe at once
        tick(1);
    endtask
    task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
        rd = 1'b1;
        addr = a;
        tick(1);
        rd = 1'b0;
        tick(1);
        d = rdata;
    endtask
    task automatic shift_run(input logic [15:0] w);
        int n;
        logic [9:0] exp;
        word = w;
        rst_n = 1'b0;
        tick(2);
        check("oe_in_reset", 16'h0, gpio_oe);
        rst_n = 1'b1;
        tick(2);
        check("load_oe", 16'h5, gpio_oe);
        for (n = 0; gpio_oe !== 4'h0 && n < 300; n++) tick(1);
        check("shift_len", 16'd130, 16'(n));
        if (n >= 300) report_and_stop();
        check("rst_held", 16'h0, sec_rst_n);
        for (n = 0; sec_rst_n !== 1'b1 && n < 200; n++) tick(1);
        check("hold_len", 16'h1, n >= HOLD && n <= HOLD + 5);
        if (n >= 200) report_and_stop();
        for (int i = 0; i < 4; i++) exp[i] = w[2*i] | w[2*i+1];
        exp[9:4] = w[13:8];
        check("clk_dis", exp, clk_dis);
        check("oe_after", 16'h0, gpio_oe);
        $display("shift %h done", w);
    endtask
    task automatic gpio_regs;
        logic [7:0] r;
        pin_drv = 4'ha;
        cfg_wr(8'h66, 8'hf5);
        cfg_wr(8'h64, 8'h03);
        cfg_wr(8'h64, 8'h00);
        tick(1);
        check("oe_set", 16'h5, gpio_oe);
        check("pins_drv", 16'hb, pins);
        cfg_wr(8'h65, 8'h01);
        cfg_wr(8'h67, 8'h04);
        cfg_wr(8'h68, 8'hff);
        tick(4);
        check("oe_clr", 16'h1, gpio_oe);
        cfg_rd(8'h68, r);
        check("pin_in", 16'h0a, r);
        cfg_rd(8'h70, r);
        check("unmapped", 16'h00, r);
        cfg_wr(8'h6a, 8'h03);
        cfg_wr(8'h6b, 8'h3f);
        tick(1);
        check("mask_wr", 16'h3f1, clk_dis);
        $display("gpio registers done");
    endtask
    task automatic live_swap;
        logic [7:0] r;
        int n;
        cfg_wr(8'h67, 8'h08);
        cfg_wr(8'h40, 8'h0f);
        pin_drv[3] = 1'b1;
        tick(5);
        check("halt", 16'h83, {halted, io_en, mem_en, mst_en, acc_iomem, cpl_en, drain, acc_cfg});
        cfg_rd(8'h40, r);
        check("ctrl_rd", 16'h0f, r);
        pin_drv[3] = 1'b0;
        tick(5);
        check("resume", 16'h7f, {halted, io_en, mem_en, mst_en, acc_iomem, cpl_en, drain, acc_cfg});
        mslo = 1'b0;
        pin_drv[3] = 1'b1;
        tick(6);
        check("no_live", 16'h7f, {halted, io_en, mem_en, mst_en, acc_iomem, cpl_en, drain, acc_cfg});
        pin_drv[3] = 1'b0;
        tick(6);
        check("event", 16'h0, event_n);
        cfg_wr(8'h6c, 8'h06);
        tick(2);
        check("event_clr", 16'h1, event_n);
        cfg_wr(8'h6c, 8'h01);
        tick(2);
        check("lamp", 16'h1, lamp);
        cfg_wr(8'h40, 8'h10);
        check("sw_rst", 16'h0, sec_rst_n);
        cfg_wr(8'h40, 8'h00);
        for (n = 0; sec_rst_n !== 1'b1 && n < 200; n++) tick(1);
        check("sw_hold", 16'h1, n >= HOLD && n <= HOLD + 5);
        if (n >= 200) report_and_stop();
        $display("live and swap done");
    endtask
    initial begin
        shift_run(16'h0000);
        shift_run(16'hffff);
        shift_run(16'h2c93);
        shift_run(16'hc102);
        gpio_regs();
        live_swap();
        report_and_stop();
    end
endmodule
